// [test_write_once_option_registers.sv]
// Purpose: Self-checking bench for the write-once option bank
// Assumes: One wait cycle per bus access; recovery counts shortened
// Notes: Reads are checked by a monitor against a queue of expectations

`timescale 1ns/100ps

module test_write_once_option_registers;
  // ==========================================================
  // Stimulus and observed signals
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic por_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic osc_tick = 1'b0;
  logic halt_enter = 1'b0;
  logic wake_req = 1'b0;
  logic wake_by_undervolt = 1'b0;
  logic undervolt_reset_req = 1'b0;
  logic watchdog_enable;
  logic [17:0] watchdog_timeout;
  logic undervolt_power_on;
  logic undervolt_voltage_mode;
  logic undervolt_reset_out;
  logic cpu_release;
  logic halt_opcode_legal;
  logic illegal_halt;
  logic serial_baud_clock_source;
  logic oscillator_on_in_halt;
  logic [7:0] option_three;
  int err_count = 0;
  int check_count = 0;
  int n;
  integer seed = 32'hd7ff;
  logic [7:0] v1, v2, v3;
  logic [31:0] exp_q[$];

  always #12.5 clk_sys = ~clk_sys;
  // Oscillator tick at half the bus rate
  always @(posedge clk_sys) osc_tick <= ~osc_tick;

  // Short counts keep the halt and power-on waits brief
  wor_option_bank #(
    .POR_STAB_CYCLES(13'h0008),
    .REC_LONG_CYCLES(13'h0008),
    .REC_SHORT_CYCLES(13'h0002)
  ) u_wor_option_bank (
    .clk_sys(clk_sys), .rst_n(rst_n), .por_n(por_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .osc_tick(osc_tick),
    .halt_enter(halt_enter), .wake_req(wake_req),
    .wake_by_undervolt(wake_by_undervolt),
    .undervolt_reset_req(undervolt_reset_req),
    .watchdog_enable(watchdog_enable),
    .watchdog_timeout(watchdog_timeout),
    .undervolt_power_on(undervolt_power_on),
    .undervolt_voltage_mode(undervolt_voltage_mode),
    .undervolt_reset_out(undervolt_reset_out),
    .cpu_release(cpu_release), .halt_opcode_legal(halt_opcode_legal),
    .illegal_halt(illegal_halt),
    .serial_baud_clock_source(serial_baud_clock_source),
    .oscillator_on_in_halt(oscillator_on_in_halt),
    .option_three(option_three)
  );

  // ==========================================================
  // Shared tasks
  task check(input string name, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task finish_test;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Upper data bits are random; only lane 0 is meaningful
  task bus(input logic wr, input logic [7:0] addr, input logic [7:0] d);
    int k;
    logic [31:0] r;
    @(posedge clk_sys);
    avs_address <= addr;
    avs_write <= wr;
    avs_read <= !wr;
    r = $random(seed);
    avs_writedata <= {r[23:0], d};
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    if (k >= 20)
      check("bus_answer", 1'b1, 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task rd(input logic [7:0] addr, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus(1'b0, addr, 8'h00);
  endtask

  task do_reset(input logic por);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    por_n <= !por;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    por_n <= 1'b1;
  endtask

  task pulse_halt;
    @(posedge clk_sys);
    halt_enter <= 1'b1;
    @(posedge clk_sys);
    halt_enter <= 1'b0;
  endtask

  task wake(input logic by_uv);
    @(posedge clk_sys);
    wake_req <= 1'b1;
    wake_by_undervolt <= by_uv;
    @(posedge clk_sys);
    wake_req <= 1'b0;
    n = 0;
    while (cpu_release !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    wake_by_undervolt <= 1'b0;
  endtask

  // Read monitor takes the oldest expectation at each read answer
  always @(posedge clk_sys) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0)
        check("read_unexpected", 32'h1, 32'h0);
      else
        check("readdata", avs_readdata, exp_q.pop_front());
    end
  end

  initial begin
    #(25 * 6000);
    err_count++;
    finish_test;
  end

  // ==========================================================
  // Main sequence
  initial begin
    v1 = $random(seed);
    v2 = $random(seed);
    v3 = $random(seed);
    do_reset(1'b1);
    repeat (3) @(posedge clk_sys);
    check("por_hold", cpu_release, 1'b0);
    check("wd_en_rst", watchdog_enable, 1'b1);
    check("wd_to_rst", watchdog_timeout, 18'h3fff0);
    check("uv_pwr_rst", undervolt_power_on, 1'b1);
    n = 0;
    while (cpu_release !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    check("por_wait", (n >= 9 && n <= 22), 1'b1);
    rd(8'h7c, 8'h00);
    rd(8'h78, 8'h00);
    rd(8'h24, 8'h00);
    // Writes to option one, then a second write that must not land
    bus(1'b1, 8'h7c, v1);
    bus(1'b1, 8'h7c, ~v1);
    rd(8'h7c, v1);
    bus(1'b1, 8'h78, v2);
    bus(1'b1, 8'h78, ~v2);
    rd(8'h78, v2);
    bus(1'b1, 8'h24, v3);
    bus(1'b1, 8'h40, 8'h5a);
    rd(8'h40, 8'h00);
    rd(8'h24, v3);
    rd(8'h00, 8'h00);
    repeat (2) @(posedge clk_sys);
    check("wd_en", watchdog_enable, !v1[0]);
    check("wd_to", watchdog_timeout,
          v1[7] ? 18'h01ff0 : 18'h3fff0);
    check("uv_pwr", undervolt_power_on, !v1[4]);
    check("uv_mode", undervolt_voltage_mode, v1[3]);
    check("halt_legal", halt_opcode_legal, v1[1]);
    check("baud_src", serial_baud_clock_source, v2[0]);
    check("osc_halt", oscillator_on_in_halt, v2[1]);
    check("opt_three", option_three, v3);
    undervolt_reset_req <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check("uv_rst", undervolt_reset_out, !v1[5]);
    undervolt_reset_req <= 1'b0;
    // Plain reset keeps only the voltage-mode bit
    do_reset(1'b0);
    repeat (3) @(posedge clk_sys);
    rd(8'h7c, {4'h0, v1[3], 3'h0});
    rd(8'h78, 8'h00);
    // Halt with the halt bit clear is an illegal opcode
    pulse_halt;
    @(posedge clk_sys);
    check("illegal_halt", illegal_halt, 1'b1);
    check("no_halt", cpu_release, 1'b1);
    // Oscillator kept on in halt before short recovery is chosen
    bus(1'b1, 8'h78, 8'h02);
    // Fast rate, short recovery, halt allowed, monitor off in halt
    bus(1'b1, 8'h7c, 8'h86);
    rd(8'h7c, 8'h86);
    repeat (2) @(posedge clk_sys);
    check("wd_to_fast", watchdog_timeout, 18'h01ff0);
    check("osc_on", oscillator_on_in_halt, 1'b1);
    pulse_halt;
    repeat (2) @(posedge clk_sys);
    check("halted", cpu_release, 1'b0);
    check("uv_halt_off", undervolt_power_on, 1'b0);
    wake(1'b0);
    check("short_rec", (n >= 1 && n <= 8), 1'b1);
    check("uv_run_on", undervolt_power_on, 1'b1);
    pulse_halt;
    repeat (2) @(posedge clk_sys);
    wake(1'b1);
    check("uv_wake_long", (n >= 12 && n <= 24), 1'b1);
    repeat (2) @(posedge clk_sys);
    finish_test;
  end
endmodule // test_write_once_option_registers

// [wor_once_reg.sv]
// Purpose: One option register that takes a single write per reset
// Assumes: Both resets are synchronous and active low
// Notes: Bits in POR_ONLY_MASK survive a reset that is not power-on

`timescale 1ns/100ps

module wor_once_reg #(
  parameter int unsigned WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VAL = '0,
  parameter logic [WIDTH-1:0] POR_ONLY_MASK = '0
) (
  // Clock and resets
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic por_n,
  // Write strobe, already qualified by the bus
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  // Latched option value
  output logic [WIDTH-1:0] value_q,
  output logic locked_q
);

  // ==========================================================
  // Value
  always_ff @(posedge clk_sys) begin
    if (!por_n) begin
      value_q <= RESET_VAL;
    end else if (!rst_n) begin
      value_q <= (RESET_VAL & ~POR_ONLY_MASK) |
                 (value_q & POR_ONLY_MASK);
    end else if (wr_en && !locked_q) begin
      value_q <= wr_data;
    end
  end

  // ==========================================================
  // Lock, private to this register so others stay writable
  always_ff @(posedge clk_sys) begin
    if (!por_n || !rst_n) begin
      locked_q <= 1'b0;
    end else if (wr_en) begin
      locked_q <= 1'b1;
    end
  end

  // ==========================================================
  // Checks
  a_lock_hold: assert property (@(posedge clk_sys)
    disable iff (!rst_n || !por_n)
    locked_q |=> $stable(value_q))
    else $error("option register changed after its one write");

  a_por_only_keep: assert property (@(posedge clk_sys)
    disable iff (!por_n)
    !rst_n |=> ((value_q & POR_ONLY_MASK) ==
                ($past(value_q) & POR_ONLY_MASK)))
    else $error("power-on-only bit lost on a plain reset");

endmodule // wor_once_reg

// [wor_option_bank.sv]
// Purpose: Write-once system option registers on an Avalon-MM slave
// Assumes: osc_tick is a one-cycle pulse per oscillator clock cycle
// Notes: Every access waits exactly one cycle; unmapped reads give 0
// Notes on behaviour
// - Each option register takes one write per reset; reset clears it, save the voltage-mode bit on a plain reset.
// - The three registers decode at indices 09, 1E and 1F.
// - Reads are allowed any time and return latched values.
// - Watchdog timeout is 8176 cycles when rate bit set, else 262128.
// - Watchdog disable bit set turns the watchdog off.
// - Monitor runs in halt only if its halt-enable bit is set.
// - Monitor reset request is blocked while reset-disable bit is set.
// - Monitor power-disable bit set powers the monitor down.
// - Voltage-mode bit picks 5 V when set; only power-on clears it.
// - Short recovery bit gives 32-cycle halt exit, else 4096.
// - Wake by monitor reset always uses the long recovery.
// - Power-on and long recovery both wait 4096 oscillator cycles.
// - Halt enable set runs halt; clear makes it an illegal opcode.
// - Baud source bit set picks the bus clock, else oscillator clock.
//
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.

`timescale 1ns/100ps

module wor_option_bank #(
  parameter logic [17:0] WD_LONG_CYCLES = wor_pkg::WD_LONG_CYC,
  parameter logic [17:0] WD_SHORT_CYCLES = wor_pkg::WD_SHORT_CYC,
  parameter logic [12:0] REC_LONG_CYCLES = wor_pkg::REC_LONG_CYC,
  parameter logic [12:0] REC_SHORT_CYCLES = wor_pkg::REC_SHORT_CYC,
  parameter logic [12:0] POR_STAB_CYCLES = wor_pkg::POR_STAB_CYC
) (
  // Clock and resets
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic por_n,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // System events
  input wire logic osc_tick,
  input wire logic halt_enter,
  input wire logic wake_req,
  input wire logic wake_by_undervolt,
  input wire logic undervolt_reset_req,
  // Watchdog controls
  output logic watchdog_enable,
  output logic [17:0] watchdog_timeout,
  // Undervoltage monitor controls
  output logic undervolt_power_on,
  output logic undervolt_voltage_mode,
  output logic undervolt_reset_out,
  // CPU and clocking controls
  output logic cpu_release,
  output logic halt_opcode_legal,
  output logic illegal_halt,
  output logic serial_baud_clock_source,
  output logic oscillator_on_in_halt,
  output logic [7:0] option_three
);

  // ==========================================================
  // Bus decode
  logic [5:0] idx;
  logic req;
  logic accept;
  logic wr_ok;
  logic hit_one;
  logic hit_two;
  logic hit_three;
  logic [7:0] opt_one;
  logic [7:0] opt_two;
  logic [7:0] opt_three;
  logic lock_one;
  logic lock_two;
  logic lock_three;
  logic [7:0] rd_mux;

  assign idx = avs_address[7:2];
  assign req = avs_read || avs_write;
  // Request completes at the edge where waitrequest is low
  assign accept = req && !avs_waitrequest;
  // Byte lane 0 carries the option byte; other lanes are ignored
  assign wr_ok = avs_write && accept && avs_byteenable[0];
  assign hit_one = (avs_address[1:0] == 2'h0) &&
                   (idx == wor_pkg::IDX_OPT_ONE);
  assign hit_two = (avs_address[1:0] == 2'h0) &&
                   (idx == wor_pkg::IDX_OPT_TWO);
  assign hit_three = (avs_address[1:0] == 2'h0) &&
                     (idx == wor_pkg::IDX_OPT_THREE);

  always_comb begin
    rd_mux = 8'h00;
    if (hit_one) begin
      rd_mux = opt_one;
    end else if (hit_two) begin
      rd_mux = opt_two;
    end else if (hit_three) begin
      rd_mux = opt_three;
    end
  end

  // ==========================================================
  // Option registers, one lock each
  wor_once_reg #(
    .WIDTH(8),
    .RESET_VAL(wor_pkg::OPT_RESET),
    .POR_ONLY_MASK(wor_pkg::ONE_POR_ONLY_MASK)
  ) u_opt_one (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .por_n(por_n),
    .wr_en(wr_ok && hit_one),
    .wr_data(avs_writedata[7:0]),
    .value_q(opt_one),
    .locked_q(lock_one)
  );

  wor_once_reg #(
    .WIDTH(8),
    .RESET_VAL(wor_pkg::OPT_RESET),
    .POR_ONLY_MASK(wor_pkg::NO_POR_ONLY_MASK)
  ) u_opt_two (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .por_n(por_n),
    .wr_en(wr_ok && hit_two),
    .wr_data(avs_writedata[7:0]),
    .value_q(opt_two),
    .locked_q(lock_two)
  );

  wor_once_reg #(
    .WIDTH(8),
    .RESET_VAL(wor_pkg::OPT_RESET),
    .POR_ONLY_MASK(wor_pkg::NO_POR_ONLY_MASK)
  ) u_opt_three (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .por_n(por_n),
    .wr_en(wr_ok && hit_three),
    .wr_data(avs_writedata[7:0]),
    .value_q(opt_three),
    .locked_q(lock_three)
  );

  // ==========================================================
  // Bus handshake: one wait cycle, data captured as it drops
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !por_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(req && avs_waitrequest);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || !por_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= {24'h00_0000, rd_mux};
    end
  end

  // ==========================================================
  // Halt and recovery sequencer
  wor_pkg::wor_state_type state_q;
  logic [12:0] cnt_q;
  logic in_halt;

  assign in_halt = (state_q == wor_pkg::ST_HALT);

  always_ff @(posedge clk_sys) begin
    if (!por_n) begin
      state_q <= wor_pkg::ST_POR;
      cnt_q <= POR_STAB_CYCLES;
    end else if (!rst_n) begin
      state_q <= wor_pkg::ST_RUN;
      cnt_q <= 13'h0000;
    end else begin
      unique case (state_q)
        wor_pkg::ST_RUN: begin
          if (halt_enter && opt_one[wor_pkg::BIT_HALT_EN]) begin
            state_q <= wor_pkg::ST_HALT;
          end
        end
        wor_pkg::ST_HALT: begin
          if (wake_req) begin
            state_q <= wor_pkg::ST_RECOV;
            // Monitor wake ignores the short option
            if (wake_by_undervolt ||
                !opt_one[wor_pkg::BIT_SHORT_REC]) begin
              cnt_q <= REC_LONG_CYCLES;
            end else begin
              cnt_q <= REC_SHORT_CYCLES;
            end
          end
        end
        wor_pkg::ST_POR, wor_pkg::ST_RECOV: begin
          if (osc_tick) begin
            cnt_q <= cnt_q - 13'h0001;
            if (cnt_q == 13'h0001) begin
              state_q <= wor_pkg::ST_RUN;
            end
          end
        end
        default: begin
          state_q <= wor_pkg::ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || !por_n) begin
      illegal_halt <= 1'b0;
    end else begin
      illegal_halt <= (state_q == wor_pkg::ST_RUN) && halt_enter &&
                      !opt_one[wor_pkg::BIT_HALT_EN];
    end
  end

  // ==========================================================
  // Option outputs, refreshed every cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !por_n) begin
      watchdog_enable <= 1'b1;
      watchdog_timeout <= WD_LONG_CYCLES;
    end else begin
      watchdog_enable <= !opt_one[wor_pkg::BIT_WD_DIS];
      watchdog_timeout <= opt_one[wor_pkg::BIT_WD_RATE] ?
                          WD_SHORT_CYCLES : WD_LONG_CYCLES;
    end
  end

  // Monitor stays powered out of reset so the POR wait is covered
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !por_n) begin
      undervolt_power_on <= 1'b1;
      undervolt_reset_out <= 1'b0;
    end else begin
      undervolt_power_on <= !opt_one[wor_pkg::BIT_UV_PWRD] &&
                            (!in_halt ||
                             opt_one[wor_pkg::BIT_UV_HALT]);
      undervolt_reset_out <= undervolt_reset_req &&
                             !opt_one[wor_pkg::BIT_UV_RSTD];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || !por_n) begin
      cpu_release <= 1'b0;
      halt_opcode_legal <= 1'b0;
      serial_baud_clock_source <= 1'b0;
      oscillator_on_in_halt <= 1'b0;
      option_three <= 8'h00;
      undervolt_voltage_mode <= 1'b0;
    end else begin
      cpu_release <= (state_q == wor_pkg::ST_RUN);
      halt_opcode_legal <= opt_one[wor_pkg::BIT_HALT_EN];
      serial_baud_clock_source <= opt_two[wor_pkg::BIT_BAUD_SRC];
      oscillator_on_in_halt <= opt_two[wor_pkg::BIT_OSC_HALT];
      option_three <= opt_three;
      undervolt_voltage_mode <= opt_one[wor_pkg::BIT_UV_MODE];
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n || !por_n);

  a_wait_one_cycle: assert property (
    req && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered after one wait cycle");
  a_read_returns_value: assert property (
    avs_read && !avs_waitrequest && hit_one |->
      avs_readdata == {24'h00_0000, opt_one})
    else $error("read of option one returned wrong data");
  a_second_write_ignored: assert property (
    lock_two && wr_ok && hit_two |=> $stable(opt_two))
    else $error("locked option two accepted a second write");
  a_locks_separate: assert property (
    wr_ok && hit_one && !lock_two |=> !lock_two)
    else $error("write to option one locked option two");
  a_wd_timeout: assert property (
    1'b1 |=> watchdog_timeout == ($past(opt_one[wor_pkg::BIT_WD_RATE]) ?
             WD_SHORT_CYCLES : WD_LONG_CYCLES))
    else $error("watchdog timeout does not follow rate bit");
  a_wd_disable: assert property (
    $rose(opt_one[wor_pkg::BIT_WD_DIS]) |=> !watchdog_enable)
    else $error("watchdog still enabled after disable bit set");
  a_uv_power: assert property (
    opt_one[wor_pkg::BIT_UV_PWRD] |=> !undervolt_power_on)
    else $error("monitor powered while power-disable set");
  a_uv_halt: assert property (
    in_halt && !opt_one[wor_pkg::BIT_UV_HALT] |=>
      !undervolt_power_on)
    else $error("monitor running in halt without its enable");
  a_uv_reset: assert property (
    undervolt_reset_req && !opt_one[wor_pkg::BIT_UV_RSTD] |=>
      undervolt_reset_out)
    else $error("monitor reset request not passed");
  a_recov_len: assert property (
    in_halt && wake_req && wake_by_undervolt |=>
      cnt_q == REC_LONG_CYCLES && state_q == wor_pkg::ST_RECOV)
    else $error("monitor wake did not load long recovery");
  a_recov_short: assert property (
    in_halt && wake_req && !wake_by_undervolt &&
    opt_one[wor_pkg::BIT_SHORT_REC] |=> cnt_q == REC_SHORT_CYCLES)
    else $error("short recovery not loaded");
  a_cpu_held: assert property (
    state_q == wor_pkg::ST_POR |=> !cpu_release)
    else $error("cpu released during power-on wait");
  a_halt_illegal: assert property (
    state_q == wor_pkg::ST_RUN && halt_enter &&
    !opt_one[wor_pkg::BIT_HALT_EN] |=> illegal_halt ##1 !illegal_halt)
    else $error("disabled halt not flagged as illegal");
  a_baud_source: assert property (
    1'b1 |=> serial_baud_clock_source ==
             $past(opt_two[wor_pkg::BIT_BAUD_SRC]))
    else $error("baud clock source does not follow option");

  c_write_one: cover property (wr_ok && hit_one);
  c_relock_try: cover property (lock_one && wr_ok && hit_one);
  c_halt_recover: cover property (
    in_halt ##1 state_q == wor_pkg::ST_RECOV);
  c_por_done: cover property (
    state_q == wor_pkg::ST_POR ##1 state_q == wor_pkg::ST_RUN);

endmodule // wor_option_bank

// [wor_pkg.sv]
// Purpose: Shared constants and types for the write-once option bank
// Assumes: Register index times four gives the Avalon byte address
// Notes: Timing figures are counted in oscillator clock ticks

package wor_pkg;

  // ==========================================================
  // Register map (word index, byte address = index * 4)
  localparam logic [5:0] IDX_OPT_THREE = 6'h09;
  localparam logic [5:0] IDX_OPT_TWO = 6'h1e;
  localparam logic [5:0] IDX_OPT_ONE = 6'h1f;
  localparam logic [7:0] OPT_RESET = 8'h00;

  // ==========================================================
  // Field positions, option register one
  localparam int unsigned BIT_WD_RATE = 7;
  localparam int unsigned BIT_UV_HALT = 6;
  localparam int unsigned BIT_UV_RSTD = 5;
  localparam int unsigned BIT_UV_PWRD = 4;
  localparam int unsigned BIT_UV_MODE = 3;
  localparam int unsigned BIT_SHORT_REC = 2;
  localparam int unsigned BIT_HALT_EN = 1;
  localparam int unsigned BIT_WD_DIS = 0;
  // Bits that only power-on reset clears
  localparam logic [7:0] ONE_POR_ONLY_MASK = 8'h08;
  localparam logic [7:0] NO_POR_ONLY_MASK = 8'h00;

  // ==========================================================
  // Field positions, option register two
  localparam int unsigned BIT_OSC_HALT = 1;
  localparam int unsigned BIT_BAUD_SRC = 0;

  // ==========================================================
  // Timing in oscillator cycles
  localparam logic [17:0] WD_SHORT_CYC = 18'h01ff0;
  localparam logic [17:0] WD_LONG_CYC = 18'h3fff0;
  localparam logic [12:0] REC_SHORT_CYC = 13'h0020;
  localparam logic [12:0] REC_LONG_CYC = 13'h1000;
  localparam logic [12:0] POR_STAB_CYC = 13'h1000;

  // ==========================================================
  // Halt and recovery sequencer
  typedef enum logic [3:0] {
    ST_RUN = 4'b0001,
    ST_POR = 4'b0010,
    ST_HALT = 4'b0100,
    ST_RECOV = 4'b1000
  } wor_state_type;

endpackage
